// file: core/dcdc_clock_pkg.sv
package dcdc_clock_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CONVERTER_CONFIG_ADDR  = 8'h96;
	localparam logic [7:0] CONVERTER_CONFIG_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED          = 8'h00;

	// ----------------------------------------------------------------
	// field positions of converter_config_reg
	// ----------------------------------------------------------------
	localparam int LOW_POWER_ENABLE_BIT     = 7;
	localparam int CONV_CLOCK_DIVIDER_HI    = 6;
	localparam int CONV_CLOCK_DIVIDER_LO    = 5;
	localparam int ADC_CLOCK_POLARITY_BIT   = 4;
	localparam int CONV_CLOCK_INVERT_BIT    = 3;
	localparam int PEAK_CURRENT_SELECT_BIT  = 2;
	localparam int SLEEP_SUPPLY_CONNECT_BIT = 1;
	localparam int CONV_CLOCK_SOURCE_BIT    = 0;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic       SOURCE_LOCAL_OSC = 1'b0;
	localparam logic       SOURCE_SYSTEM    = 1'b1;
	localparam logic [1:0] DIVIDE_BY_1      = 2'h0;
	localparam logic [1:0] DIVIDE_BY_2      = 2'h1;
	localparam logic [1:0] DIVIDE_BY_4      = 2'h2;
	localparam logic [1:0] DIVIDE_BY_8      = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	// low time forced on the converter clock across a reconfiguration;
	// covers one low half period at the slowest divider
	localparam int         PARK_CYCLES    = 8;
	localparam int         PARK_CNT_W     = 4;
	localparam int         DIV_CNT_W      = 3;

endpackage : dcdc_clock_pkg

// file: core/conv_clock_if.sv
`timescale 1ns/1ns
interface conv_clock_if;
	logic [1:0] div_code;
	logic       restart;
	logic       phase;

	modport ctrl (
		output div_code,
		output restart,
		input  phase
	);

	modport gen (
		input  div_code,
		input  restart,
		output phase
	);
endinterface : conv_clock_if

// file: core/conv_clock_div.sv
`timescale 1ns/1ns
module conv_clock_div
	import dcdc_clock_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic srst,
	conv_clock_if.gen div_if
);

	typedef struct packed {
		logic [DIV_CNT_W-1:0] cnt;
		logic                 phase;
	} div_state_s;

	div_state_s st;
	div_state_s next_st;
	logic [DIV_CNT_W-1:0] last_count;
	logic                 wrap;

	// ----------------------------------------------------------------
	// divider: phase toggles every 2^div_code cycles
	// ----------------------------------------------------------------
	always_comb begin
		last_count = DIV_CNT_W'((1 << div_if.div_code) - 1);
		wrap       = (st.cnt >= last_count);
		next_st    = st;
		if (div_if.restart) begin
			// restart lands on the start of a low half period
			next_st.cnt   = '0;
			next_st.phase = 1'b0;
		end else if (wrap) begin
			next_st.cnt   = '0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + DIV_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign div_if.phase    = st.phase;

endmodule : conv_clock_div

// file: core/dcdc_clock_config.sv
// Operation
// - converter clocked from local oscillator when source bit 0, system clock when 1
// - system clock divided by 2, 4, 8 or 16 per divider field (half period of 1, 2, 4 or 8 cycles)
// - divider field has no effect while local oscillator is the source
// - invert bit 1 inverts the divided system clock at the divider output, 0 leaves it uninverted
// - with sync on, polarity bit 0 inverts ADC clock, 1 passes it
// - ADC polarity bit ignored while converter sync control bit is zero
// - low-power bit 1 enters converter low-power mode, 0 leaves it
// - sleep with converter on: bit 0 ties supply to battery, 1 floats
// - current-limit select bit picks one of two peak current thresholds
`timescale 1ns/1ns
module dcdc_clock_config
	import dcdc_clock_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       local_osc_clk,
	input  wire logic       conv_sync_enable,
	input  wire logic       sleep_mode,
	input  wire logic       conv_enable,
	output logic            conv_clk,
	output logic            adc_sar_clk,
	output logic            conv_clk_busy,
	output logic            low_power_enable,
	output logic            peak_current_select,
	output logic            supply_to_battery,
	output logic            supply_floating
);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// one-hot; any stray code falls to the default branch and reruns
	typedef enum logic [2:0] {
		CLK_RUN   = 3'b001,
		CLK_DRAIN = 3'b010,
		CLK_PARK  = 3'b100
	} clk_fsm_e;

	typedef struct packed {
		logic [7:0]            config_reg;
		logic [7:0]            rdata;
		clk_fsm_e              fsm;
		logic                  act_source;
		logic [1:0]            act_divider;
		logic                  act_invert;
		logic [PARK_CNT_W-1:0] park_cnt;
		logic                  conv_clk;
		logic                  adc_clk;
		logic                  busy;
		logic                  low_power;
		logic                  peak_sel;
		logic                  to_battery;
		logic                  floating;
	} state_s;

	state_s st;
	state_s next_st;

	conv_clock_if div_if ();

	conv_clock_div u_div (
		.core_clk (core_clk),
		.srst     (srst),
		.div_if   (div_if)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic clk_level(
		input logic source,
		input logic invert,
		input logic phase,
		input logic osc
	);
		logic sys_level;
		sys_level = phase ^ invert;
		clk_level = (source == SOURCE_SYSTEM) ? sys_level : osc;
	endfunction : clk_level

	logic       req_source;
	logic [1:0] req_divider;
	logic       req_invert;
	logic       cfg_change;
	logic       cur_level;
	logic       new_level;
	logic       conv_next;
	logic       reg_hit;

	always_comb begin
		req_source  = st.config_reg[CONV_CLOCK_SOURCE_BIT];
		req_divider = st.config_reg[CONV_CLOCK_DIVIDER_HI:CONV_CLOCK_DIVIDER_LO];
		req_invert  = st.config_reg[CONV_CLOCK_INVERT_BIT];
		// divider and inversion only matter for the system clock path
		cfg_change  = (req_source != st.act_source)
			|| ((req_source == SOURCE_SYSTEM)
			&& ((req_divider != st.act_divider)
			|| (req_invert != st.act_invert)));
		reg_hit     = (sfr_addr == CONVERTER_CONFIG_ADDR);
		cur_level   = clk_level(st.act_source, st.act_invert,
			div_if.phase, local_osc_clk);
		new_level   = clk_level(req_source, req_invert,
			div_if.phase, local_osc_clk);
	end

	// ----------------------------------------------------------------
	// divider control
	// ----------------------------------------------------------------
	assign div_if.div_code = st.act_divider;
	// restart only once the old clock is low, so no high phase is cut short
	assign div_if.restart  = (st.fsm == CLK_DRAIN) && !cur_level;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st   = st;
		conv_next = st.conv_clk;

		// register access
		if (sfr_wr && reg_hit) begin
			next_st.config_reg = sfr_wdata;
		end
		// read and write in one cycle returns the old value
		if (sfr_rd) begin
			next_st.rdata = reg_hit ? st.config_reg : READ_UNMAPPED;
		end

		// converter clock switch sequencer
		case (st.fsm)
			CLK_RUN: begin
				conv_next = cur_level;
				if (cfg_change) begin
					next_st.fsm = CLK_DRAIN;
				end
			end
			CLK_DRAIN: begin
				// wait for the old clock to be low, then freeze it there
				conv_next = cur_level;
				if (!cur_level) begin
					conv_next           = 1'b0;
					next_st.act_source  = req_source;
					next_st.act_invert  = req_invert;
					if (req_source == SOURCE_SYSTEM) begin
						next_st.act_divider = req_divider;
					end
					next_st.park_cnt    = PARK_CNT_W'(PARK_CYCLES - 1);
					next_st.fsm         = CLK_PARK;
				end
			end
			CLK_PARK: begin
				// hold low a full half period; release only while the new
				// clock is itself low so its first high is whole
				conv_next = 1'b0;
				if (st.park_cnt != '0) begin
					next_st.park_cnt = st.park_cnt - PARK_CNT_W'(1);
				end else if (!cur_level) begin
					next_st.fsm = CLK_RUN;
				end
			end
			default: begin
				conv_next   = 1'b0;
				next_st.fsm = CLK_RUN;
			end
		endcase
		next_st.conv_clk = conv_next;
		// busy follows the next state so it rises with the drain request
		next_st.busy     = (next_st.fsm != CLK_RUN);

		// sampling clock follows the converter clock, aligned to it
		// taken from conv_next so both clocks leave the same flop edge
		if (conv_sync_enable) begin
			next_st.adc_clk = st.config_reg[ADC_CLOCK_POLARITY_BIT]
				? conv_next : ~conv_next;
		end else begin
			next_st.adc_clk = 1'b0;
		end

		// analog control levels
		// levels only; the analog side owns the thresholds and switches
		next_st.low_power  = st.config_reg[LOW_POWER_ENABLE_BIT];
		next_st.peak_sel   = st.config_reg[PEAK_CURRENT_SELECT_BIT];
		next_st.to_battery = sleep_mode && conv_enable
			&& !st.config_reg[SLEEP_SUPPLY_CONNECT_BIT];
		next_st.floating   = sleep_mode && conv_enable
			&& st.config_reg[SLEEP_SUPPLY_CONNECT_BIT];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			// a switch in flight is abandoned; the oscillator path restarts
			st            <= '0;
			st.config_reg <= CONVERTER_CONFIG_RESET;
			st.rdata      <= READ_UNMAPPED;
			st.fsm        <= CLK_RUN;
			st.act_source <= SOURCE_LOCAL_OSC;
			st.act_divider <= DIVIDE_BY_1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sfr_rdata           = st.rdata;
	assign conv_clk            = st.conv_clk;
	assign adc_sar_clk         = st.adc_clk;
	assign conv_clk_busy       = st.busy;
	assign low_power_enable    = st.low_power;
	assign peak_current_select = st.peak_sel;
	assign supply_to_battery   = st.to_battery;
	assign supply_floating     = st.floating;

endmodule : dcdc_clock_config

// file: dv/dcdc_clock_config_asserts.sv
`timescale 1ns/1ns
module dcdc_clock_config_asserts
	import dcdc_clock_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       local_osc_clk,
	input wire logic       conv_sync_enable,
	input wire logic       sleep_mode,
	input wire logic       conv_enable,
	input wire logic       conv_clk,
	input wire logic       adc_sar_clk,
	input wire logic       conv_clk_busy,
	input wire logic       low_power_enable,
	input wire logic       peak_current_select,
	input wire logic       supply_to_battery,
	input wire logic       supply_floating
);
	// ----
	// config shadow and level run lengths
	// ----
	logic [7:0] cfg;
	logic [5:0] quiet;
	logic [7:0] hi_len;
	logic [7:0] lo_len;
	logic       hit;
	assign hit = sfr_wr && sfr_addr == CONVERTER_CONFIG_ADDR;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg    <= CONVERTER_CONFIG_RESET;
			quiet  <= 6'h0;
			hi_len <= 8'h0;
			lo_len <= 8'h0;
		end else begin
			cfg    <= hit ? sfr_wdata : cfg;
			// saturate so a long quiet spell never wraps back into the settle window
			quiet  <= hit ? 6'h0 : quiet + {5'h0, quiet != 6'h3f};
			hi_len <= conv_clk ? hi_len + {7'h0, hi_len != 8'hff} : 8'h0;
			lo_len <= conv_clk ? 8'h0 : lo_len + {7'h0, lo_len != 8'hff};
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	AST_LOW_POWER: assert property (quiet > 6'h2 |-> low_power_enable == cfg[7])
		else $error("low power output wrong");
	AST_PEAK: assert property (quiet > 6'h2 |-> peak_current_select == cfg[2])
		else $error("peak current select wrong");
	AST_SUPPLY: assert property (quiet > 6'h2 && $stable(sleep_mode) && $stable(conv_enable)
		|-> supply_to_battery == (sleep_mode && conv_enable && !cfg[1])
		&& supply_floating == (sleep_mode && conv_enable && cfg[1]))
		else $error("sleep supply connection wrong");
	AST_ADC_POL: assert property (quiet > 6'h2 && conv_sync_enable && $past(conv_sync_enable)
		|-> adc_sar_clk == (conv_clk ^ !cfg[4])) else $error("adc clock polarity wrong");
	AST_ADC_OFF: assert property (!conv_sync_enable && !$past(conv_sync_enable)
		|-> !adc_sar_clk) else $error("adc clock active with sync off");
	AST_LOCAL: assert property (quiet > 6'h2 && !cfg[0] && !conv_clk_busy
		&& !$past(conv_clk_busy) |-> conv_clk == $past(local_osc_clk))
		else $error("converter clock not from local oscillator");
	AST_SYS_HALF: assert property ($fell(conv_clk) && cfg[0] && quiet > 6'h2
		&& !conv_clk_busy |-> hi_len == 8'h01 << cfg[6:5]) else $error("half period wrong");
	AST_PARK: assert property ($fell(conv_clk_busy) |-> lo_len >= PARK_CYCLES - 1)
		else $error("converter clock not parked low");
	AST_RDATA: assert property (sfr_rd |=> sfr_rdata ==
		($past(sfr_addr) == CONVERTER_CONFIG_ADDR ? $past(cfg) : READ_UNMAPPED))
		else $error("read data wrong");
	cover property ($fell(conv_clk) && cfg[0] && quiet > 6'h2 && !conv_clk_busy);
	cover property ($fell(conv_clk_busy));
	cover property (conv_sync_enable && adc_sar_clk);
endmodule : dcdc_clock_config_asserts

bind dcdc_clock_config dcdc_clock_config_asserts i_asserts (
	.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.local_osc_clk(local_osc_clk), .conv_sync_enable(conv_sync_enable),
	.sleep_mode(sleep_mode), .conv_enable(conv_enable), .conv_clk(conv_clk),
	.adc_sar_clk(adc_sar_clk), .conv_clk_busy(conv_clk_busy),
	.low_power_enable(low_power_enable), .peak_current_select(peak_current_select),
	.supply_to_battery(supply_to_battery), .supply_floating(supply_floating)
);

// file: dv/dcdc_clock_config_bench.sv
`timescale 1ns/1ns
module dcdc_clock_config_bench
	import dcdc_clock_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic       local_osc_clk = 1'b0;
	logic       conv_sync_enable = 1'b0;
	logic       sleep_mode = 1'b0;
	logic       conv_enable = 1'b0;
	logic       conv_clk, adc_sar_clk, conv_clk_busy;
	logic       low_power_enable, peak_current_select, supply_to_battery, supply_floating;
	logic [2:0] osc_cnt = 3'h0;
	int         fail_count = 0;
	int         comparisons = 0;

	dcdc_clock_config i_dut (
		.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.local_osc_clk(local_osc_clk), .conv_sync_enable(conv_sync_enable),
		.sleep_mode(sleep_mode), .conv_enable(conv_enable), .conv_clk(conv_clk),
		.adc_sar_clk(adc_sar_clk), .conv_clk_busy(conv_clk_busy),
		.low_power_enable(low_power_enable), .peak_current_select(peak_current_select),
		.supply_to_battery(supply_to_battery), .supply_floating(supply_floating)
	);

	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		osc_cnt       <= osc_cnt + 3'h1;
		local_osc_clk <= osc_cnt[1];
	end
	// ----
	// helpers
	// ----
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge core_clk);
		sfr_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge core_clk);
		sfr_rd   <= 1'b0;
		#1;
		chk("rdata", sfr_rdata, exp);
	endtask : rd
	task automatic wait_lvl(input logic v);
		for (int n = 0; n < 100 && conv_clk_busy !== v && !v !== conv_clk; n++)
			cyc(1);
	endtask : wait_lvl
	task automatic wait_run();
		int n;
		cyc(4);
		for (n = 0; n < 100 && conv_clk_busy !== 1'b0; n++)
			cyc(1);
		chk("busy", conv_clk_busy, 8'h00);
	endtask : wait_run
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		chk("outs", {low_power_enable, peak_current_select, conv_clk, conv_clk_busy}, 8'h00);
		rd(CONVERTER_CONFIG_ADDR, CONVERTER_CONFIG_RESET);
		wr(CONVERTER_CONFIG_ADDR, 8'h84);
		rd(CONVERTER_CONFIG_ADDR, 8'h84);
		wr(8'ha6, 8'hff);
		rd(8'ha6, READ_UNMAPPED);
		rd(CONVERTER_CONFIG_ADDR, 8'h84);
		chk("lp_pk", {low_power_enable, peak_current_select}, 8'h03);
		wr(CONVERTER_CONFIG_ADDR, 8'h00);
		cyc(3);
		chk("lp_pk", {low_power_enable, peak_current_select}, 8'h00);
	endtask : t_regs
	task automatic t_sleep();
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			sleep_mode  <= 1'b1;
			conv_enable <= i < 2;
			wr(CONVERTER_CONFIG_ADDR, i == 1 ? 8'h02 : 8'h00);
			cyc(3);
			chk("supply", {supply_to_battery, supply_floating}, 8'(i == 0 ? 2 : i == 1));
		end
	endtask : t_sleep
	task automatic t_div();
		int n;
		for (int d = 0; d < 4; d++) begin
			wr(CONVERTER_CONFIG_ADDR, 8'h01 | 8'(d << 5) | 8'(d % 2 << 3));
			wait_run();
			for (n = 0; n < 40 && conv_clk !== 1'b0; n++)
				cyc(1);
			for (n = 0; n < 40 && conv_clk !== 1'b1; n++)
				cyc(1);
			for (n = 0; n < 40 && conv_clk === 1'b1; n++)
				cyc(1);
			chk("half", 8'(n), 8'h01 << d);
		end
	endtask : t_div
	task automatic t_local_adc();
		logic p;
		wr(CONVERTER_CONFIG_ADDR, 8'h68);
		wait_run();
		for (int i = 0; i < 8; i++) begin
			p = local_osc_clk;
			cyc(1);
			chk("local", conv_clk, p);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			conv_sync_enable <= i < 2;
			wr(CONVERTER_CONFIG_ADDR, i % 2 ? 8'h10 : 8'h00);
			cyc(3);
			chk("busy", conv_clk_busy, 8'h00);
			repeat (4) begin
				cyc(1);
				chk("adc", adc_sar_clk, 8'(i < 2 && (conv_clk ^ (i % 2 == 0))));
			end
		end
	endtask : t_local_adc
	task automatic t_reset();
		wr(CONVERTER_CONFIG_ADDR, 8'h85);
		cyc(2);
		chk("busy", conv_clk_busy, 8'h01);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		cyc(1);
		chk("rst", {low_power_enable, peak_current_select, conv_clk_busy}, 8'h00);
		rd(CONVERTER_CONFIG_ADDR, CONVERTER_CONFIG_RESET);
	endtask : t_reset
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		cyc(1);
		t_regs();
		t_sleep();
		t_div();
		t_local_adc();
		t_reset();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		print_verdict();
	end
endmodule : dcdc_clock_config_bench
